//--- logic/cet_defs.svh
`ifndef CET_DEFS_SVH
`define CET_DEFS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define CET_OFF_CTRL        8'h00
`define CET_OFF_TEETH       8'h04
`define CET_OFF_STATUS      8'h08
`define CET_OFF_CLEAR       8'h0C

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CET_CTRL_SYNC_EN    0
`define CET_CTRL_ENCODER    1
`define CET_CTRL_RETARD     2
`define CET_CTRL_FOUR       3
`define CET_CTRL_GATE       4
`define CET_CTRL_INVERT     5
`define CET_CTRL_OFS_LSB    8
`define CET_CTRL_EXT_LSB    16
`define CET_CTRL_RESET      32'h0000_0000
`define CET_TEETH_RESET     12'h03C

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define CET_STAT_SYNC       0
`define CET_STAT_FAULT      1
`define CET_STAT_CAM_LSB    2
`define CET_STAT_IDX_LSB    16
`define CET_CLEAR_BIT       0

// ----------------------------------------------------------------
// interpolation
// ----------------------------------------------------------------
`define CET_TICK_SHIFT      9
`define CET_TICK_LAST       9'h1FF

`endif

//--- logic/cet_pkg.sv
`default_nettype none
package cet_pkg;
    typedef enum logic [1:0] {
        cet_st_stop = 2'b00,
        cet_st_arm  = 2'b01,
        cet_st_sync = 2'b11
    } cet_state_t;

    typedef enum logic [1:0] {
        cet_cam_normal = 2'b00,
        cet_cam_high   = 2'b01,
        cet_cam_low    = 2'b10,
        cet_cam_error  = 2'b11
    } cet_cam_t;
endpackage
`default_nettype wire

//--- logic/cet_tick_if.sv
`default_nettype none
interface cet_tick_if;
    logic       tooth_evt;
    logic       run;
    logic       tick;
    logic [8:0] tick_pos;

    modport src    (output tooth_evt, output run, input tick, input tick_pos);
    modport interp (input tooth_evt, input run, output tick, output tick_pos);
endinterface
`default_nettype wire

//--- logic/cet_angle_interp.sv
`include "cet_defs.svh"
`default_nettype none
module cet_angle_interp (
    input  wire logic   clk,
    input  wire logic   sys_rst,
    cet_tick_if.interp  tk
);
    logic [23:0] period_cnt_reg;
    logic [23:0] period_reg;
    logic [23:0] timer_reg;
    logic [23:0] step;
    logic        tick_reg;
    logic [8:0]  pos_reg;

    // ----------------------------------------------------------------
    // tooth period measurement
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            period_cnt_reg <= 24'h000000;
            period_reg     <= 24'h000000;
        end else if (tk.tooth_evt) begin
            period_reg     <= period_cnt_reg + 24'h000001;
            period_cnt_reg <= 24'h000000;
        end else if (period_cnt_reg != 24'hFFFFFF) begin
            period_cnt_reg <= period_cnt_reg + 24'h000001;
        end
    end

    // slow teeth give a coarse step; never below one cycle
    assign step = ((period_reg >> `CET_TICK_SHIFT) == 24'h000000) ? 24'h000001
                : (period_reg >> `CET_TICK_SHIFT);

    // ----------------------------------------------------------------
    // tick generation, 512 per regular tooth of 512 cycles or more, one per cycle on shorter teeth
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            timer_reg <= 24'h000000;
            pos_reg   <= 9'h000;
            tick_reg  <= 1'b0;
        end else if (tk.tooth_evt || !tk.run) begin
            timer_reg <= 24'h000000;
            pos_reg   <= 9'h000;
            tick_reg  <= tk.tooth_evt && tk.run;
        end else if (pos_reg != `CET_TICK_LAST && timer_reg + 24'h000001 >= step) begin
            timer_reg <= 24'h000000;
            pos_reg   <= pos_reg + 9'h001;
            tick_reg  <= 1'b1;
        end else begin
            timer_reg <= timer_reg + 24'h000001;
            tick_reg  <= 1'b0;
        end
    end

    assign tk.tick     = tick_reg;
    assign tk.tick_pos = pos_reg;
endmodule // cet_angle_interp
`default_nettype wire

//--- logic/cet_tracker.sv
// Register access over APB and the address map were decided locally.
`include "cet_defs.svh"
`default_nettype none
module cet_tracker (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        crank_tooth_input,
    input  wire logic        cam_phase_input,
    input  wire logic        index_reference_input,
    output var  logic [12:0] tooth_index,
    output var  logic        tracking_state,
    output var  logic        extra_tooth_missed_fault,
    output var  logic [1:0]  cam_pattern_report,
    output var  logic        angle_tick
);
    logic [31:0]         ctrl_reg;
    logic [11:0]         teeth_reg;
    logic [31:0]         rd_next;
    logic                wr_en;
    logic                mapped;
    logic                fault_clear;
    logic                sync_en, encoder, retard, four, gate_sel, invert;
    logic [7:0]          cam_ofs, cam_ext;
    logic                crank_d_reg, cam_d_reg, ref_d_reg;
    logic                crank_rise, cam_rise;
    logic [23:0]         since_reg, prev_int_reg;
    logic                short_gap, extra_evt, reg_evt;
    logic [12:0]         top, half;
    logic                shaped_reg, waiting_reg;
    logic [7:0]          ofs_left_reg, ext_left_reg;
    logic                cam_sig;
    logic                ref_level, ref_rise, ref_pend_reg, ref_hit;
    cet_pkg::cet_state_t state_reg;
    logic [12:0]         idx_reg;
    logic                fault_reg, extra_ok, miss;
    logic                samp_top_reg, samp_half_reg;
    cet_pkg::cet_cam_t   cam_rep_reg;
    cet_tick_if          tk ();

    // ----------------------------------------------------------------
    // apb slave, zero wait states
    // ----------------------------------------------------------------
    assign mapped = (paddr == `CET_OFF_CTRL) || (paddr == `CET_OFF_TEETH)
                 || (paddr == `CET_OFF_STATUS) || (paddr == `CET_OFF_CLEAR);
    assign wr_en       = psel && penable && pwrite && mapped;
    assign pready      = 1'b1;
    assign pslverr     = psel && penable && !mapped;
    assign fault_clear = wr_en && (paddr == `CET_OFF_CLEAR) && pwdata[`CET_CLEAR_BIT];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_reg  <= `CET_CTRL_RESET;
            teeth_reg <= `CET_TEETH_RESET;
        end else if (wr_en && paddr == `CET_OFF_CTRL) begin
            ctrl_reg  <= pwdata & 32'h00FF_FF3F;
        end else if (wr_en && paddr == `CET_OFF_TEETH) begin
            teeth_reg <= pwdata[11:0];
        end
    end

    always_comb begin
        rd_next = 32'h0000_0000;
        case (paddr)
            `CET_OFF_CTRL:   rd_next = ctrl_reg;
            `CET_OFF_TEETH:  rd_next = {20'h00000, teeth_reg};
            `CET_OFF_STATUS: begin
                rd_next[`CET_STAT_SYNC]                    = tracking_state;
                rd_next[`CET_STAT_FAULT]                   = fault_reg;
                rd_next[`CET_STAT_CAM_LSB +: 2]            = cam_rep_reg;
                rd_next[`CET_STAT_IDX_LSB +: 13]           = idx_reg;
            end
            default:         rd_next = 32'h0000_0000;
        endcase
    end

    // read data captured in the setup phase so it is stable in access
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_next;
        end
    end

    assign sync_en  = ctrl_reg[`CET_CTRL_SYNC_EN];
    assign encoder  = ctrl_reg[`CET_CTRL_ENCODER];
    assign retard   = ctrl_reg[`CET_CTRL_RETARD];
    assign four     = ctrl_reg[`CET_CTRL_FOUR];
    assign gate_sel = ctrl_reg[`CET_CTRL_GATE];
    assign invert   = ctrl_reg[`CET_CTRL_INVERT];
    assign cam_ofs  = ctrl_reg[`CET_CTRL_OFS_LSB +: 8];
    assign cam_ext  = ctrl_reg[`CET_CTRL_EXT_LSB +: 8];

    // ----------------------------------------------------------------
    // tooth edges and spacing
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            crank_d_reg <= 1'b0;
            cam_d_reg   <= 1'b0;
            ref_d_reg   <= 1'b0;
        end else begin
            crank_d_reg <= crank_tooth_input;
            cam_d_reg   <= cam_phase_input;
            ref_d_reg   <= ref_level;
        end
    end

    assign crank_rise = crank_tooth_input && !crank_d_reg;
    assign cam_rise   = cam_phase_input && !cam_d_reg;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            since_reg    <= 24'h000000;
            prev_int_reg <= 24'h000000;
        end else if (crank_rise) begin
            since_reg    <= 24'h000001;
            prev_int_reg <= since_reg;
        end else if (since_reg != 24'hFFFFFF) begin
            since_reg    <= since_reg + 24'h000001;
        end
    end

    // an interval under half the previous one marks the extra tooth pair:
    // advanced, this edge is the extra tooth; retarded, the extra tooth was
    // the previous edge, which had already stepped, so this one does not
    assign short_gap = (prev_int_reg != 24'h000000)
                    && ({since_reg, 1'b0} < {1'b0, prev_int_reg});
    assign extra_evt = !encoder && crank_rise && short_gap;
    assign reg_evt   = crank_rise && !extra_evt;

    assign half = {1'b0, teeth_reg} - 13'h0001;
    assign top  = four ? ({teeth_reg, 1'b0} - 13'h0001) : half;

    // ----------------------------------------------------------------
    // cam offset and extension, in regular teeth
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            waiting_reg  <= 1'b0;
            shaped_reg   <= 1'b0;
            ofs_left_reg <= 8'h00;
            ext_left_reg <= 8'h00;
        end else if (cam_rise) begin
            waiting_reg  <= 1'b1;
            ofs_left_reg <= cam_ofs;
        end else if (reg_evt && waiting_reg) begin
            if (ofs_left_reg == 8'h00) begin
                waiting_reg  <= 1'b0;
                shaped_reg   <= 1'b1;
                ext_left_reg <= cam_ext;
            end else begin
                ofs_left_reg <= ofs_left_reg - 8'h01;
            end
        end else if (reg_evt && shaped_reg) begin
            if (ext_left_reg == 8'h00) begin
                shaped_reg   <= 1'b0;
            end else begin
                ext_left_reg <= ext_left_reg - 8'h01;
            end
        end
    end

    // with no adjustment set the raw cam level passes straight through
    assign cam_sig = (cam_ofs == 8'h00 && cam_ext == 8'h00) ? cam_phase_input
                   : shaped_reg;

    // ----------------------------------------------------------------
    // index reference path
    // ----------------------------------------------------------------
    always_comb begin
        ref_level = index_reference_input ^ invert;
        if (four && gate_sel) begin
            ref_level = ref_level && cam_sig;
        end
    end

    // in 360 degree mode the ungated index takes the cam role
    assign ref_rise = ref_level && !ref_d_reg;
    assign ref_hit  = encoder && crank_rise && ref_pend_reg;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ref_pend_reg <= 1'b0;
        end else if (ref_rise) begin
            ref_pend_reg <= 1'b1;
        end else if (ref_hit || !encoder) begin
            ref_pend_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // synchronisation and tooth index
    // ----------------------------------------------------------------
    assign extra_ok = (idx_reg == top) || (four && idx_reg == half);
    assign miss = (state_reg == cet_pkg::cet_st_sync)
               && ((extra_evt && !extra_ok) || (ref_hit && idx_reg != top));

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fault_reg <= 1'b0;
        end else if (miss) begin
            fault_reg <= 1'b1;
        end else if (fault_clear) begin
            fault_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= cet_pkg::cet_st_stop;
            idx_reg   <= 13'h0000;
        end else if (!sync_en || miss) begin
            state_reg <= cet_pkg::cet_st_stop;
            idx_reg   <= 13'h0000;
        end else begin
            case (state_reg)
                cet_pkg::cet_st_stop: begin
                    idx_reg <= 13'h0000;
                    if (!fault_reg) begin
                        state_reg <= cet_pkg::cet_st_arm;
                    end
                end
                cet_pkg::cet_st_arm: begin
                    // top here means the next regular tooth becomes zero
                    if (extra_evt && (!four || cam_sig)) begin
                        state_reg <= cet_pkg::cet_st_sync;
                        idx_reg   <= top;
                    end else if (ref_hit) begin
                        state_reg <= cet_pkg::cet_st_sync;
                        idx_reg   <= 13'h0000;
                    end
                end
                cet_pkg::cet_st_sync: begin
                    // cam ignored here: the extra tooth, or the index in encoder mode, holds phase
                    if (reg_evt) begin
                        idx_reg <= (idx_reg >= top) ? 13'h0000
                                 : idx_reg + 13'h0001;
                    end
                end
                default: begin
                    state_reg <= cet_pkg::cet_st_stop;
                    idx_reg   <= 13'h0000;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // cam pattern report
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            samp_top_reg  <= 1'b1;
            samp_half_reg <= 1'b0;
        end else if (state_reg == cet_pkg::cet_st_sync && four && extra_evt && extra_ok) begin
            if (idx_reg == top) begin
                samp_top_reg  <= cam_sig;
            end else begin
                samp_half_reg <= cam_sig;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cam_rep_reg <= cet_pkg::cet_cam_normal;
        end else begin
            case ({samp_top_reg, samp_half_reg})
                2'b10:   cam_rep_reg <= cet_pkg::cet_cam_normal;
                2'b11:   cam_rep_reg <= cet_pkg::cet_cam_high;
                2'b00:   cam_rep_reg <= cet_pkg::cet_cam_low;
                default: cam_rep_reg <= cet_pkg::cet_cam_error;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // angle interpolation and outputs
    // ----------------------------------------------------------------
    assign tk.tooth_evt = reg_evt;
    assign tk.run       = (state_reg == cet_pkg::cet_st_sync);

    cet_angle_interp u_interp (
        .clk     (clk),
        .sys_rst (sys_rst),
        .tk      (tk.interp)
    );

    assign tooth_index              = idx_reg;
    assign tracking_state           = (state_reg == cet_pkg::cet_st_sync);
    assign extra_tooth_missed_fault = fault_reg;
    assign cam_pattern_report       = cam_rep_reg;
    assign angle_tick               = tk.tick;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_stop_index_zero: assert property (
        (state_reg != cet_pkg::cet_st_sync) |-> (idx_reg == 13'h0000 && !tracking_state))
        else $error("index not zero while stopped");

    a_fault_blocks_sync: assert property (
        (fault_reg && !fault_clear) |=> (state_reg != cet_pkg::cet_st_sync))
        else $error("resynchronised with fault latched");

    a_miss_drops_sync: assert property (
        (tracking_state && extra_evt && !extra_ok && sync_en)
        |=> (fault_reg && !tracking_state && tooth_index == 13'h0000))
        else $error("early extra tooth did not fault");

    a_extra_no_step: assert property (
        (tracking_state && extra_evt && extra_ok && sync_en) |=> $stable(tooth_index))
        else $error("extra tooth stepped the index");

    a_index_wraps: assert property (
        (tracking_state && reg_evt && idx_reg == top && !miss && sync_en)
        |=> (tooth_index == 13'h0000))
        else $error("index did not wrap at top");

    a_index_bound: assert property (
        tracking_state |-> (tooth_index <= top || $changed(ctrl_reg) || $changed(teeth_reg)))
        else $error("index beyond cycle length");

    a_encoder_zero: assert property (
        (state_reg == cet_pkg::cet_st_arm && ref_hit && sync_en)
        |=> (tracking_state && tooth_index == 13'h0000) ##1 (tooth_index <= 13'h0001))
        else $error("encoder zero not on first tooth after index");

    a_index_gated: assert property (
        (four && gate_sel && cam_ofs == 8'h00 && cam_ext == 8'h00 && !cam_phase_input)
        |-> !ref_rise)
        else $error("index passed while cam gate closed");

    a_two_stroke_acq: assert property (
        (state_reg == cet_pkg::cet_st_arm && !four && extra_evt && sync_en)
        |=> (tracking_state && tooth_index == half))
        else $error("two-stroke acquisition depended on cam");

endmodule // cet_tracker
`default_nettype wire

//--- tb/cet_wheel_model.sv
`default_nettype none
// ----------
// wheel source
// ----------
module cet_wheel_model (
    input  wire logic        clk,
    input  wire logic        run,
    input  wire logic [10:0] per,
    input  wire logic [3:0]  nt,
    input  wire logic        retard,
    input  wire logic        enc,
    input  wire logic        four,
    input  wire logic        gate,
    input  wire logic        inv,
    output var  logic        crank,
    output var  logic        cam,
    output var  logic        index,
    output var  logic        samp,
    output var  logic        camh,
    output var  logic [3:0]  slot
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [10:0] ph;
    logic [10:0] off;
    logic        xt;
    always_ff @(posedge clk) begin
        if (!run) begin
            ph <= 11'h000;
            slot <= 4'h0;
            cam <= 1'b0;
            camh <= 1'b0;
        end else if (ph == per - 11'h001) begin
            ph <= 11'h000;
            slot <= (slot == nt - 4'h1) ? 4'h0 : slot + 4'h1;
            if (slot == nt - 4'h1) camh <= cam;
            // edge kept far from the extra tooth
            if (slot == 4'h1) cam <= !cam;
        end else begin
            ph <= ph + 11'h001;
        end
    end
    assign off = retard ? per - (per >> 2) : per >> 2;
    assign xt = run && slot == nt - 4'h1 && ph >= off && ph < off + 11'h004;
    assign crank = run && (ph < 11'h004 || (xt && !enc));
    // cam-mounted reference fires every other turn in four-stroke mode unless the device gates it
    assign index = inv ^ (xt && enc && (!four || gate || cam));
    assign samp = run && ph == 11'h008;
endmodule // cet_wheel_model
`default_nettype wire

//--- tb/crank_extra_tooth_encoder_tracker_tb.sv
`include "cet_defs.svh"
`default_nettype none
module crank_extra_tooth_encoder_tracker_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic        four;
        logic        retard;
        logic        enc;
        logic [12:0] top;
        logic [12:0] after;
        logic        gate;
        logic        inv;
        logic [15:0] shape;
    } cet_row_t;
    logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, err, trk, flt, tick;
    logic        crank, cam, index, samp, camh, run, retard, enc;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [12:0] idx, mx;
    logic [1:0]  report;
    logic [3:0]  nt, slot;
    logic [10:0] per;
    int          n_fail, total_checks, hits, tk, cycles = 0;
    cet_row_t    cur;
    cet_row_t    rows [9] = '{
        '{1'b0, 1'b0, 1'b0, 13'h5, 13'h0, 1'b0, 1'b0, 16'h0000},
        '{1'b0, 1'b1, 1'b0, 13'h5, 13'h5, 1'b0, 1'b0, 16'h0000},
        '{1'b1, 1'b0, 1'b0, 13'hB, 13'h0, 1'b0, 1'b0, 16'h0000},
        '{1'b1, 1'b1, 1'b0, 13'hB, 13'hB, 1'b0, 1'b0, 16'h0000},
        '{1'b0, 1'b0, 1'b1, 13'h5, 13'h0, 1'b0, 1'b0, 16'h0000},
        '{1'b1, 1'b0, 1'b1, 13'hB, 13'h0, 1'b0, 1'b0, 16'h0000},
        '{1'b1, 1'b0, 1'b1, 13'hB, 13'h0, 1'b1, 1'b0, 16'h0000},
        '{1'b0, 1'b0, 1'b1, 13'h5, 13'h0, 1'b0, 1'b1, 16'h0000},
        '{1'b1, 1'b0, 1'b0, 13'hB, 13'h0, 1'b0, 1'b0, 16'h0301}};
    cet_tracker uut (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .crank_tooth_input(crank), .cam_phase_input(cam),
        .index_reference_input(index), .tooth_index(idx), .tracking_state(trk),
        .extra_tooth_missed_fault(flt), .cam_pattern_report(report), .angle_tick(tick));
    cet_wheel_model wheel (.clk(clk), .run(run), .per(per), .nt(nt), .retard(retard),
        .enc(enc), .four(cur.four), .gate(cur.gate), .inv(cur.inv),
        .crank(crank), .cam(cam), .index(index), .samp(samp), .camh(camh),
        .slot(slot));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            n_fail = n_fail + 1;
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_slot(input logic [3:0] s);
        do @(negedge clk); while (!(samp && slot == s));
    endtask
    // indices are sampled 8 cycles into the tooth, away from the launching edges
    always @(negedge clk) begin
        if (trk === 1'b1 && idx > mx) mx = idx;
        if (samp && slot == 4'h0 && trk === 1'b1 && (camh || !cur.four)) begin
            hits++;
            chk(32'(idx), 32'(cur.after));
        end
    end
    task automatic run_row(input cet_row_t r);
        apb(1'b1, `CET_OFF_CTRL, 32'h0);
        run <= 1'b0;
        cur = r;
        retard <= r.retard;
        enc <= r.enc;
        apb(1'b1, `CET_OFF_CTRL, {8'h0, r.shape, 2'b0, r.inv, r.gate,
            r.four, r.retard, r.enc, 1'b1});
        run <= 1'b1;
        mx = 13'h0;
        hits = 0;
        repeat (24 * int'(per)) @(posedge clk);
        @(negedge clk);
        chk(32'(trk), 32'h1);
        chk(32'(mx), 32'(r.top));
        chk(32'(hits > 0), 32'h1);
        if (r.four) chk(32'(report), 32'(cet_pkg::cet_cam_normal));
        $display("test pattern row done");
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, run, retard, enc} = '0;
        sys_rst = 1'b1;
        per = 11'h040;
        nt = 4'h6;
        cur = rows[0];
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        chk({idx, trk, flt}, 32'h0);
        apb(1'b0, `CET_OFF_TEETH, 32'h0);
        chk(rd, 32'(`CET_TEETH_RESET));
        apb(1'b0, 8'h10, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        apb(1'b1, `CET_OFF_TEETH, 32'h6);
        $display("test reset done");
        for (int i = 0; i < 9; i++) run_row(rows[i]);
        run_row(rows[0]);
        wait_slot(4'h0);
        @(posedge clk);
        nt <= 4'h4;
        wait_slot(4'h0);
        @(posedge clk);
        nt <= 4'h6;
        chk({idx, trk, flt}, 32'h1);
        repeat (1152) @(posedge clk);
        chk(32'(trk), 32'h0);
        apb(1'b0, `CET_OFF_STATUS, 32'h0);
        chk(32'(rd[`CET_STAT_FAULT]), 32'h1);
        apb(1'b1, `CET_OFF_CLEAR, 32'h1);
        @(negedge clk);
        chk(32'(flt), 32'h0);
        repeat (1152) @(posedge clk);
        chk(32'(trk), 32'h1);
        $display("test fault done");
        per <= 11'h400;
        run_row(rows[0]);
        wait_slot(4'h2);
        tk = 0;
        repeat (1024) begin
            @(negedge clk);
            tk += int'(tick);
        end
        chk(32'(tk), 32'h200);
        $display("test ticks done");
        complete_run();
    end
endmodule // crank_extra_tooth_encoder_tracker_tb
`default_nettype wire
